// >>> logic/cbc_pkg.sv
// Constants, opcodes and state encoding for the bit and control operation core
package cbc_pkg;
	// Vectors, each high byte at the even address
	localparam logic [15:0] VEC_RESET   = 16'hfffe;
	localparam logic [15:0] VEC_SWI     = 16'hfffc;
	localparam logic [15:0] VEC_IRQ     = 16'hfffa;
	localparam logic [15:0] VEC_LO_BYTE = 16'h0001;

	// Reset values
	localparam logic [7:0]  SP_TOP      = 8'hff;
	localparam logic [4:0]  CCR_RESET   = 5'h08;
	localparam logic [2:0]  CCR_UNUSED  = 3'h7;
	localparam logic [7:0]  PAGE_ZERO   = 8'h00;

	// Condition code bit positions
	localparam int CCR_H = 4;
	localparam int CCR_I = 3;
	localparam int CCR_N = 2;
	localparam int CCR_Z = 1;
	localparam int CCR_C = 0;

	// Direct page map: ports, direction registers, timer, RAM
	localparam logic [7:0]  PORT_BASE   = 8'h00;
	localparam logic [7:0]  PORT_LAST   = 8'h02;
	localparam logic [7:0]  DDR_BASE    = 8'h04;
	localparam logic [7:0]  DDR_LAST    = 8'h06;
	localparam logic [7:0]  TIMER_BASE  = 8'h08;
	localparam logic [7:0]  TIMER_LAST  = 8'h09;
	localparam logic [7:0]  RAM_BASE    = 8'h80;
	localparam logic [2:0]  REG_PORT    = 3'h1;
	localparam logic [2:0]  REG_DDR     = 3'h2;
	localparam logic [2:0]  REG_TIMER   = 3'h3;
	localparam logic [2:0]  REG_RAM     = 3'h4;
	localparam logic [2:0]  REG_OTHER   = 3'h0;

	// Bit operation group: top three opcode bits zero
	localparam logic [2:0]  BIT_GROUP   = 3'h0;
	localparam logic [2:0]  LAST_STEP   = 3'h4;
	localparam logic [2:0]  RTS_STEP    = 3'h3;

	// Control opcodes, inherent addressing
	localparam logic [7:0] OP_RTI  = 8'h80;
	localparam logic [7:0] OP_RTS  = 8'h81;
	localparam logic [7:0] OP_SWI  = 8'h83;
	localparam logic [7:0] OP_STOP = 8'h8e;
	localparam logic [7:0] OP_WAIT = 8'h8f;
	localparam logic [7:0] OP_TAX  = 8'h97;
	localparam logic [7:0] OP_CLC  = 8'h98;
	localparam logic [7:0] OP_SEC  = 8'h99;
	localparam logic [7:0] OP_CLI  = 8'h9a;
	localparam logic [7:0] OP_SEI  = 8'h9b;
	localparam logic [7:0] OP_RSP  = 8'h9c;
	localparam logic [7:0] OP_NOP  = 8'h9d;
	localparam logic [7:0] OP_TXA  = 8'h9f;

	typedef enum logic [3:0] {
		S_VEC_H  = 4'h0,
		S_VEC_L  = 4'h1,
		S_VEC_D  = 4'h2,
		S_FETCH  = 4'h3,
		S_DECODE = 4'h4,
		S_DIR    = 4'h5,
		S_OPND   = 4'h6,
		S_REL    = 4'h7,
		S_PUSH   = 4'h8,
		S_PULL   = 4'h9,
		S_PULLD  = 4'ha,
		S_STOP   = 4'hb,
		S_WAIT   = 4'hc
	} cbc_state_t;

	// One-hot mask of a selected bit
	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = 8'h01 << sel;
	endfunction
endpackage

// >>> logic/cbc_bit_unit.sv
// Bit modify, bit test and direct page region decode
`timescale 1ns/1ns
module cbc_bit_unit (
	input  wire logic [7:0] data_in,
	input  wire logic [2:0] sel_in,
	input  wire logic       set_in,
	input  wire logic [7:0] dir_addr_in,
	output logic      [7:0] modified_out,
	output logic            tested_out,
	output logic      [2:0] region_out
);
	////////////////////////////////////////////////////////////////////////
	// Force one bit high or low, report its old level
	always_comb begin
		if (set_in) begin
			modified_out = data_in | cbc_pkg::bit_mask(sel_in);
		end else begin
			modified_out = data_in & ~cbc_pkg::bit_mask(sel_in);
		end
		tested_out = |(data_in & cbc_pkg::bit_mask(sel_in));
	end

	////////////////////////////////////////////////////////////////////////
	// Class of the direct page location
	always_comb begin
		if (dir_addr_in <= cbc_pkg::PORT_LAST) begin
			region_out = cbc_pkg::REG_PORT;
		end else if (dir_addr_in >= cbc_pkg::DDR_BASE && dir_addr_in <= cbc_pkg::DDR_LAST) begin
			region_out = cbc_pkg::REG_DDR;
		end else if (dir_addr_in >= cbc_pkg::TIMER_BASE &&
				dir_addr_in <= cbc_pkg::TIMER_LAST) begin
			region_out = cbc_pkg::REG_TIMER;
		end else if (dir_addr_in >= cbc_pkg::RAM_BASE) begin
			region_out = cbc_pkg::REG_RAM;
		end else begin
			region_out = cbc_pkg::REG_OTHER;
		end
	end
endmodule

// >>> logic/cbc_core.sv
// Core executing bit operations and inherent control operations
//
// What this block does
// - Set or clear any bit, first 256 bytes
// - Branch on any bit, first 256 bytes
// - Ports, directions, timer, RAM below 256
// - Bit operations take one direct address byte
// - Control operations are inherent, opcode only
// - Stop halts oscillator, enables interrupt pin wake
// - Wait halts core clock, clears interrupt mask
// - Accumulator copied into index, accumulator kept
// - Index copied into accumulator, index kept
// - Bit branch copies tested bit to carry
// - Bit branch: opcode, address, signed offset
// - Offset signed, added to next address
`timescale 1ns/1ns
module cbc_core (
	input  wire logic        ref_clk_in,
	input  wire logic        nrst_in,
	input  wire logic        irq_pin_n_in,
	input  wire logic [7:0]  mem_rdata_in,
	output logic      [15:0] mem_addr_out,
	output logic             mem_rd_out,
	output logic             mem_wr_out,
	output logic      [7:0]  mem_wdata_out,
	output logic      [2:0]  mem_region_out,
	output logic      [7:0]  acc_out,
	output logic      [7:0]  index_out,
	output logic      [7:0]  sp_out,
	output logic      [4:0]  ccr_out,
	output logic      [15:0] pc_out,
	output logic             osc_halt_out,
	output logic             core_halt_out,
	output logic             irq_wake_en_out
);
	cbc_pkg::cbc_state_t state, next_state;
	logic [15:0] pc, next_pc, vec, next_vec;
	logic [7:0]  acc, next_acc, idx, next_idx, sp, next_sp, ir, next_ir, dir, next_dir;
	logic [4:0]  ccr, next_ccr;
	logic [2:0]  step, next_step, region, next_region;
	logic        osc_halt, next_osc_halt, core_halt, next_core_halt;
	logic        wake_en, next_wake_en;
	logic        irq_meta, irq_sync, irq_req;
	logic [7:0]  modified;
	logic        tested;
	logic [2:0]  dir_region;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser for the interrupt pin
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			irq_meta <= 1'b1;
			irq_sync <= 1'b1;
		end else begin
			irq_meta <= irq_pin_n_in;
			irq_sync <= irq_meta;
		end
	end
	assign irq_req = ~irq_sync;

	// Bit modify, test and region decode
	cbc_bit_unit u_bit (
		.data_in      (mem_rdata_in),
		.sel_in       (ir[3:1]),
		.set_in       (~ir[0]),
		.dir_addr_in  (dir),
		.modified_out (modified),
		.tested_out   (tested),
		.region_out   (dir_region)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer: next values and bus requests
	always_comb begin
		next_state     = state;
		next_pc        = pc;
		next_vec       = vec;
		next_acc       = acc;
		next_idx       = idx;
		next_sp        = sp;
		next_ir        = ir;
		next_dir       = dir;
		next_ccr       = ccr;
		next_step      = step;
		next_region    = region;
		next_osc_halt  = osc_halt;
		next_core_halt = core_halt;
		next_wake_en   = wake_en;
		mem_addr_out   = 16'h0000;
		mem_rd_out     = 1'b0;
		mem_wr_out     = 1'b0;
		mem_wdata_out  = 8'h00;
		case (state)
			cbc_pkg::S_VEC_H: begin
				mem_addr_out = vec;
				mem_rd_out   = 1'b1;
				next_state   = cbc_pkg::S_VEC_L;
			end
			cbc_pkg::S_VEC_L: begin
				next_pc      = {mem_rdata_in, pc[7:0]};
				mem_addr_out = vec | cbc_pkg::VEC_LO_BYTE;
				mem_rd_out   = 1'b1;
				next_state   = cbc_pkg::S_VEC_D;
			end
			cbc_pkg::S_VEC_D: begin
				next_pc    = {pc[15:8], mem_rdata_in};
				next_state = cbc_pkg::S_FETCH;
			end
			cbc_pkg::S_FETCH: begin
				if (irq_req && !ccr[cbc_pkg::CCR_I]) begin
					next_vec   = cbc_pkg::VEC_IRQ;
					next_step  = 3'h0;
					next_state = cbc_pkg::S_PUSH;
				end else begin
					mem_addr_out = pc;
					mem_rd_out   = 1'b1;
					next_pc      = pc + 16'h0001;
					next_state   = cbc_pkg::S_DECODE;
				end
			end
			cbc_pkg::S_DECODE: begin
				next_ir    = mem_rdata_in;
				next_state = cbc_pkg::S_FETCH;
				if (mem_rdata_in[7:5] == cbc_pkg::BIT_GROUP) begin
					mem_addr_out = pc;
					mem_rd_out   = 1'b1;
					next_pc      = pc + 16'h0001;
					next_state   = cbc_pkg::S_DIR;
				end else begin
					case (mem_rdata_in)
						cbc_pkg::OP_TAX: next_idx = acc;
						cbc_pkg::OP_TXA: next_acc = idx;
						cbc_pkg::OP_CLC: next_ccr[cbc_pkg::CCR_C] = 1'b0;
						cbc_pkg::OP_SEC: next_ccr[cbc_pkg::CCR_C] = 1'b1;
						cbc_pkg::OP_CLI: next_ccr[cbc_pkg::CCR_I] = 1'b0;
						cbc_pkg::OP_SEI: next_ccr[cbc_pkg::CCR_I] = 1'b1;
						cbc_pkg::OP_RSP: next_sp = cbc_pkg::SP_TOP;
						cbc_pkg::OP_NOP: next_state = cbc_pkg::S_FETCH;
						cbc_pkg::OP_SWI: begin
							next_vec   = cbc_pkg::VEC_SWI;
							next_step  = 3'h0;
							next_state = cbc_pkg::S_PUSH;
						end
						cbc_pkg::OP_RTI: begin
							next_step  = 3'h0;
							next_state = cbc_pkg::S_PULL;
						end
						cbc_pkg::OP_RTS: begin
							next_step  = cbc_pkg::RTS_STEP;
							next_state = cbc_pkg::S_PULL;
						end
						cbc_pkg::OP_STOP: begin
							next_ccr[cbc_pkg::CCR_I] = 1'b0;
							next_osc_halt            = 1'b1;
							next_wake_en             = 1'b1;
							next_state               = cbc_pkg::S_STOP;
						end
						cbc_pkg::OP_WAIT: begin
							next_ccr[cbc_pkg::CCR_I] = 1'b0;
							next_core_halt           = 1'b1;
							next_state               = cbc_pkg::S_WAIT;
						end
						default: next_state = cbc_pkg::S_FETCH;
					endcase
				end
			end
			cbc_pkg::S_DIR: begin
				next_dir     = mem_rdata_in;
				mem_addr_out = {cbc_pkg::PAGE_ZERO, mem_rdata_in};
				mem_rd_out   = 1'b1;
				next_state   = cbc_pkg::S_OPND;
			end
			cbc_pkg::S_OPND: begin
				next_region = dir_region;
				if (ir[4]) begin
					mem_addr_out  = {cbc_pkg::PAGE_ZERO, dir};
					mem_wr_out    = 1'b1;
					mem_wdata_out = modified;
					next_state    = cbc_pkg::S_FETCH;
				end else begin
					next_ccr[cbc_pkg::CCR_C] = tested;
					mem_addr_out = pc;
					mem_rd_out   = 1'b1;
					next_pc      = pc + 16'h0001;
					next_state   = cbc_pkg::S_REL;
				end
			end
			cbc_pkg::S_REL: begin
				// Carry holds the tested bit; low opcode bit picks polarity
				if (ccr[cbc_pkg::CCR_C] ^ ir[0]) begin
					next_pc = pc + {{8{mem_rdata_in[7]}}, mem_rdata_in};
				end
				next_state = cbc_pkg::S_FETCH;
			end
			cbc_pkg::S_PUSH: begin
				mem_addr_out = {cbc_pkg::PAGE_ZERO, sp};
				mem_wr_out   = 1'b1;
				next_sp      = sp - 8'h01;
				case (step)
					3'h0: mem_wdata_out = pc[7:0];
					3'h1: mem_wdata_out = pc[15:8];
					3'h2: mem_wdata_out = idx;
					3'h3: mem_wdata_out = acc;
					default: mem_wdata_out = {cbc_pkg::CCR_UNUSED, ccr};
				endcase
				if (step == cbc_pkg::LAST_STEP) begin
					next_ccr[cbc_pkg::CCR_I] = 1'b1;
					next_state               = cbc_pkg::S_VEC_H;
				end else begin
					next_step = step + 3'h1;
				end
			end
			cbc_pkg::S_PULL: begin
				mem_addr_out = {cbc_pkg::PAGE_ZERO, sp + 8'h01};
				mem_rd_out   = 1'b1;
				next_sp      = sp + 8'h01;
				next_state   = cbc_pkg::S_PULLD;
			end
			cbc_pkg::S_PULLD: begin
				case (step)
					3'h0: next_ccr = mem_rdata_in[4:0];
					3'h1: next_acc = mem_rdata_in;
					3'h2: next_idx = mem_rdata_in;
					3'h3: next_pc  = {mem_rdata_in, pc[7:0]};
					default: next_pc = {pc[15:8], mem_rdata_in};
				endcase
				if (step == cbc_pkg::LAST_STEP) begin
					next_state = cbc_pkg::S_FETCH;
				end else begin
					next_step  = step + 3'h1;
					next_state = cbc_pkg::S_PULL;
				end
			end
			cbc_pkg::S_STOP, cbc_pkg::S_WAIT: begin
				// Wake on the interrupt pin into the interrupt vector
				if (irq_req) begin
					next_osc_halt  = 1'b0;
					next_core_halt = 1'b0;
					next_wake_en   = 1'b0;
					next_vec       = cbc_pkg::VEC_IRQ;
					next_step      = 3'h0;
					next_state     = cbc_pkg::S_PUSH;
				end
			end
			default: next_state = cbc_pkg::S_FETCH;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge ref_clk_in) begin
		if (!nrst_in) begin
			state     <= cbc_pkg::S_VEC_H;
			pc        <= 16'h0000;
			vec       <= cbc_pkg::VEC_RESET;
			acc       <= 8'h00;
			idx       <= 8'h00;
			sp        <= cbc_pkg::SP_TOP;
			ir        <= 8'h00;
			dir       <= 8'h00;
			ccr       <= cbc_pkg::CCR_RESET;
			step      <= 3'h0;
			region    <= cbc_pkg::REG_OTHER;
			osc_halt  <= 1'b0;
			core_halt <= 1'b0;
			wake_en   <= 1'b0;
		end else begin
			state     <= next_state;
			pc        <= next_pc;
			vec       <= next_vec;
			acc       <= next_acc;
			idx       <= next_idx;
			sp        <= next_sp;
			ir        <= next_ir;
			dir       <= next_dir;
			ccr       <= next_ccr;
			step      <= next_step;
			region    <= next_region;
			osc_halt  <= next_osc_halt;
			core_halt <= next_core_halt;
			wake_en   <= next_wake_en;
		end
	end

	// Register views
	assign acc_out         = acc;
	assign index_out       = idx;
	assign sp_out          = sp;
	assign ccr_out         = ccr;
	assign pc_out          = pc;
	assign mem_region_out  = region;
	assign osc_halt_out    = osc_halt;
	assign core_halt_out   = core_halt;
	assign irq_wake_en_out = wake_en;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);

	wire dec = (state == cbc_pkg::S_DECODE);

	chk_bit_write: assert property (
		state == cbc_pkg::S_OPND && ir[4] |-> mem_wr_out && mem_addr_out[15:8] == 8'h00
		&& (mem_wdata_out & cbc_pkg::bit_mask(ir[3:1])) == (ir[0] ? 8'h00 : cbc_pkg::bit_mask(ir[3:1])))
		else $error("bit write wrong");
	chk_branch_dest: assert property (
		state == cbc_pkg::S_REL && (ccr[0] ^ ir[0]) |=>
		pc == $past(pc) + {{8{$past(mem_rdata_in[7])}}, $past(mem_rdata_in)})
		else $error("branch target wrong");
	chk_branch_skip: assert property (
		state == cbc_pkg::S_REL && !(ccr[0] ^ ir[0]) |=> pc == $past(pc))
		else $error("untaken branch moved");
	chk_carry_copy: assert property (
		state == cbc_pkg::S_OPND && !ir[4] |=> ccr[0] == $past(tested) ##1 state == cbc_pkg::S_FETCH)
		else $error("carry not tested bit");
	chk_dir_byte: assert property (
		dec && mem_rdata_in[7:5] == 3'h0 |=> mem_rd_out && mem_addr_out[15:8] == 8'h00)
		else $error("direct fetch missing");
	chk_tax_copy: assert property (
		dec && mem_rdata_in == cbc_pkg::OP_TAX |=> idx == $past(acc) && $stable(acc))
		else $error("tax wrong");
	chk_txa_copy: assert property (
		dec && mem_rdata_in == cbc_pkg::OP_TXA |=> acc == $past(idx) && $stable(idx))
		else $error("txa wrong");
	chk_carry_ops: assert property (
		dec && (mem_rdata_in == cbc_pkg::OP_CLC || mem_rdata_in == cbc_pkg::OP_SEC) |=>
		ccr[0] == $past(mem_rdata_in[0]) && ccr[4:1] == $past(ccr[4:1]))
		else $error("carry op wrong");
	chk_idle_op: assert property (
		dec && mem_rdata_in == cbc_pkg::OP_NOP |=> $stable(acc) && $stable(idx)
		&& $stable(sp) && $stable(ccr) && $stable(pc) && state == cbc_pkg::S_FETCH)
		else $error("idle op changed state");
	chk_stop_halt: assert property (
		dec && mem_rdata_in == cbc_pkg::OP_STOP |=> osc_halt_out && irq_wake_en_out && !ccr[3])
		else $error("stop did not halt");
	chk_wait_halt: assert property (
		dec && mem_rdata_in == cbc_pkg::OP_WAIT |=> core_halt_out && !ccr[3] && !mem_rd_out)
		else $error("wait did not halt");
	chk_halt_wake: assert property (
		(state == cbc_pkg::S_WAIT || state == cbc_pkg::S_STOP) && irq_req |=>
		!core_halt_out && !osc_halt_out ##5 state == cbc_pkg::S_VEC_H)
		else $error("wake sequence wrong");

	cov_bit_set:    cover property (state == cbc_pkg::S_OPND && ir[4] && !ir[0]);
	cov_branch_tkn: cover property (state == cbc_pkg::S_REL && (ccr[0] ^ ir[0]));
	cov_wait_wake:  cover property (state == cbc_pkg::S_WAIT && irq_req);
	cov_rti_done:   cover property (state == cbc_pkg::S_PULLD && step == 3'h4);
endmodule

// >>> tb/cbc_mem_model.sv
// Memory model answering the core's bus one cycle after each read
`timescale 1ns/1ns
module cbc_mem_model (
	input  wire logic        clk_in,
	input  wire logic [15:0] addr_in,
	input  wire logic        rd_in,
	input  wire logic        wr_in,
	input  wire logic [7:0]  wdata_in,
	output logic      [7:0]  rdata_out
);
	logic [7:0] mem [0:65535];

	////////////////////////////////////////
	// Fill with the idle opcode
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h9d;
		end
		rdata_out = 8'h00;
	end

	// Answer reads next cycle, otherwise a pattern that keeps changing
	always @(posedge clk_in) begin
		if (wr_in) begin
			mem[addr_in] <= wdata_in;
		end
		if (rd_in) begin
			rdata_out <= mem[addr_in];
		end else begin
			rdata_out <= ~rdata_out;
		end
	end
endmodule

// >>> tb/cbc_core_bench.sv
// Self-checking bench for the bit and control operation core
`timescale 1ns/1ns
module cbc_core_bench;
	logic        ref_clk_in;
	logic        nrst_in;
	logic        irq_pin_n_in;
	logic [7:0]  mem_rdata_in;
	logic [15:0] mem_addr_out;
	logic        mem_rd_out;
	logic        mem_wr_out;
	logic [7:0]  mem_wdata_out;
	logic [2:0]  mem_region_out;
	logic [7:0]  acc_out;
	logic [7:0]  index_out;
	logic [7:0]  sp_out;
	logic [4:0]  ccr_out;
	logic [15:0] pc_out;
	logic        osc_halt_out;
	logic        core_halt_out;
	logic        irq_wake_en_out;
	int          n_fail;
	int          check_count;

	cbc_core u_dut (
		.ref_clk_in      (ref_clk_in),
		.nrst_in         (nrst_in),
		.irq_pin_n_in    (irq_pin_n_in),
		.mem_rdata_in    (mem_rdata_in),
		.mem_addr_out    (mem_addr_out),
		.mem_rd_out      (mem_rd_out),
		.mem_wr_out      (mem_wr_out),
		.mem_wdata_out   (mem_wdata_out),
		.mem_region_out  (mem_region_out),
		.acc_out         (acc_out),
		.index_out       (index_out),
		.sp_out          (sp_out),
		.ccr_out         (ccr_out),
		.pc_out          (pc_out),
		.osc_halt_out    (osc_halt_out),
		.core_halt_out   (core_halt_out),
		.irq_wake_en_out (irq_wake_en_out)
	);

	cbc_mem_model u_mem (
		.clk_in    (ref_clk_in),
		.addr_in   (mem_addr_out),
		.rd_in     (mem_rd_out),
		.wr_in     (mem_wr_out),
		.wdata_in  (mem_wdata_out),
		.rdata_out (mem_rdata_in)
	);

	////////////////////////////////////////
	// Clock, 10 ns period
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	// Step edges, then land just after the last one
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask

	// Compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Load bytes into memory
	task automatic put(input logic [15:0] a, input logic [7:0] b[$]);
		foreach (b[i]) u_mem.mem[a + 16'(i)] = b[i];
	endtask

	// Wait for either halt output
	task automatic halt_wait;
		int k;
		k = 0;
		while (!core_halt_out && !osc_halt_out && k < 600) begin
			step(1);
			k++;
		end
		check("halt", k < 600, 1'b1);
	endtask

	// Set wake vector, pull the pin, run until the next halt
	task automatic run(input logic [15:0] entry);
		int k;
		u_mem.mem[16'hfffa] = entry[15:8];
		u_mem.mem[16'hfffb] = entry[7:0];
		irq_pin_n_in = 1'b0;
		k = 0;
		while ((core_halt_out || osc_halt_out) && k < 20) begin
			step(1);
			k++;
		end
		check("wake", k < 20, 1'b1);
		irq_pin_n_in = 1'b1;
		halt_wait();
	endtask

	// Halted core: status outputs and a silent bus
	task automatic idle(input logic stop);
		int busy;
		check("osc halt", osc_halt_out, stop);
		check("pin wake", irq_wake_en_out, stop);
		if (!stop) check("core halt", core_halt_out, 1'b1);
		check("irq mask", ccr_out[cbc_pkg::CCR_I], 1'b0);
		busy = 0;
		repeat (4) begin
			if (mem_rd_out !== 1'b0 || mem_wr_out !== 1'b0) busy++;
			step(1);
		end
		check("bus idle", busy, 0);
	endtask

	////////////////////////////////////////
	// Set every bit at 80, clear every bit at 04
	task automatic s_bits;
		u_mem.mem[16'h0080] = 8'h00;
		u_mem.mem[16'h0004] = 8'hff;
		for (int n = 0; n < 8; n++) begin
			put(16'h0200 + 16'(4 * n), '{8'h10 + 8'(2 * n), 8'h80, 8'h11 + 8'(2 * n), 8'h04});
		end
		put(16'h0220, '{8'h8f});
		run(16'h0200);
		check("set bits", u_mem.mem[16'h0080], 8'hff);
		check("clear bits", u_mem.mem[16'h0004], 8'h00);
		check("region", mem_region_out, cbc_pkg::REG_DDR);
		check("pc", pc_out, 16'h0221);
		idle(1'b0);
	endtask

	// Bit branches: offset +127 and -128, taken and not taken
	task automatic s_branch;
		u_mem.mem[16'h0009] = 8'ha5;
		u_mem.mem[16'h0081] = 8'h00;
		put(16'h0300, '{8'h00, 8'h09, 8'h7f, 8'h16, 8'h81, 8'h03, 8'h09, 8'h02});
		put(16'h0308, '{8'h12, 8'h81, 8'h98, 8'h05, 8'h09, 8'h02, 8'h14, 8'h81, 8'h8f});
		put(16'h0382, '{8'h0e, 8'h09, 8'h80});
		run(16'h0300);
		check("branch marks", u_mem.mem[16'h0081], 8'h04);
		check("carry", ccr_out[cbc_pkg::CCR_C], 1'b1);
		check("region", mem_region_out, cbc_pkg::REG_RAM);
		check("pc", pc_out, 16'h0311);
		idle(1'b0);
	endtask

	// Frame at 0000 pulled after a stack reset, then transfer
	task automatic s_a2x;
		put(16'h0000, '{8'he6, 8'h5a, 8'hc3, 8'h04, 8'h00});
		put(16'h0400, '{8'h97, 8'h99, 8'h9d, 8'h8f});
		put(16'h0480, '{8'h9c, 8'h80});
		run(16'h0480);
		check("acc", acc_out, 8'h5a);
		check("index", index_out, 8'h5a);
		check("ccr", ccr_out, 5'h07);
		check("sp", sp_out, 8'h04);
		check("pc", pc_out, 16'h0404);
		idle(1'b0);
	endtask

	// Index to accumulator, carry clear, mask set and clear
	task automatic s_x2a;
		// First move the stack away from 0000, so the wake push cannot hit the frame
		put(16'h0580, '{8'h9c, 8'h10, 8'h02, 8'h8f});
		run(16'h0580);
		check("region", mem_region_out, cbc_pkg::REG_PORT);
		put(16'h0000, '{8'he7, 8'h5a, 8'hc3, 8'h05, 8'h00});
		put(16'h0500, '{8'h9f, 8'h98, 8'h9b, 8'h9a, 8'h8f});
		put(16'h05c0, '{8'h9c, 8'h80});
		run(16'h05c0);
		check("acc", acc_out, 8'hc3);
		check("index", index_out, 8'hc3);
		check("ccr", ccr_out, 5'h06);
		check("pc", pc_out, 16'h0505);
		idle(1'b0);
	endtask

	// Soft trap pushes its return address and vectors
	task automatic s_swi;
		logic [7:0] s0;
		s0 = sp_out;
		put(16'h0600, '{8'h83});
		put(16'h0680, '{8'h8f});
		run(16'h0600);
		check("ret lo", u_mem.mem[{8'h00, 8'(s0 - 8'h05)}], 8'h01);
		check("ret hi", u_mem.mem[{8'h00, 8'(s0 - 8'h06)}], 8'h06);
		check("sp", sp_out, 8'(s0 - 8'h0a));
		check("pc", pc_out, 16'h0681);
		idle(1'b0);
	endtask

	// Stop, then wake through the pin
	task automatic s_stop;
		put(16'h0700, '{8'h8e});
		put(16'h0780, '{8'h1f, 8'h08, 8'h8f});
		run(16'h0700);
		idle(1'b1);
		run(16'h0780);
		check("osc halt", osc_halt_out, 1'b0);
		check("region", mem_region_out, cbc_pkg::REG_TIMER);
		idle(1'b0);
	endtask

	////////////////////////////////////////
	// Counts and verdict
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#200000;
		n_fail++;
		$display("unexpected watchdog expected done seen running");
		print_verdict();
	end

	// Reset, first halt, then the scenarios
	initial begin
		nrst_in = 1'b0;
		irq_pin_n_in = 1'b1;
		n_fail = 0;
		check_count = 0;
		step(1);
		put(16'hfffc, '{8'h06, 8'h80, 8'h01, 8'h00});
		put(16'h0100, '{8'h8f});
		step(1);
		nrst_in = 1'b1;
		halt_wait();
		idle(1'b0);
		s_bits();
		s_branch();
		s_a2x();
		s_x2a();
		s_swi();
		s_stop();
		print_verdict();
	end
endmodule
